// ### hw/ssf_sample_path.sv
// Purpose: Capture simultaneous samples, buffer them, stream them to DMA
// Assumes: Sample tick and converter codes synchronous to i_sys_clk
// Notes: One tick captures all channels on the same edge
module ssf_sample_path #(
   parameter int unsigned CONV_BITS = ssf_pkg::CONV_BITS_HI
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic [2:0] i_enabled_channel_count,
   input wire logic [ssf_pkg::XFER_W-1:0] i_xfer_words,
   input wire logic i_sample_tick,
   input wire logic [CONV_BITS-1:0] i_conv_ch0,
   input wire logic [CONV_BITS-1:0] i_conv_ch1,
   input wire logic [CONV_BITS-1:0] i_conv_ch2,
   input wire logic [CONV_BITS-1:0] i_conv_ch3,
   input wire logic i_trigger_seen,
   input wire logic i_digital_input_line_a,
   input wire logic i_digital_input_line_b,
   input wire logic i_digital_input_line_c,
   input wire logic i_dma_ready,
   output logic o_dma_valid,
   output logic [ssf_pkg::WORD_W-1:0] o_dma_word,
   output logic o_busy,
   output logic o_done,
   output logic o_overflow,
   output logic o_cfg_error
);
   import ssf_pkg::*;

   localparam int unsigned PTR_W = $clog2(FIFO_WORDS);
   localparam int unsigned ADDR_W = $clog2(BANK_WORDS);
   localparam int unsigned GAP_W = $clog2(TICK_MIN_CYC + 1);
   localparam logic [PTR_W:0] FULL_LVL = (PTR_W + 1)'(FIFO_WORDS);
   localparam logic [XFER_W-1:0] MAX_LEN = XFER_W'(MAX_XFER_WORDS);
   localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(TICK_MIN_CYC - 1);
   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   if (CONV_BITS != CONV_BITS_HI && CONV_BITS != CONV_BITS_LO) begin : g_bad_bits
      $error("CONV_BITS must be 10 or 12");
   end
   if (NUM_BANKS != 2 || (1 << ADDR_W) != BANK_WORDS) begin : g_bad_bank
      $error("Storage must be two power-of-two banks");
   end
   // -------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------
   // Legal channel count settings
   function automatic logic ch_valid(input logic [2:0] cnt);
      ch_valid = (cnt == CH_NONE) || (cnt == CH_ONE) ||
                 (cnt == CH_TWO) || (cnt == CH_FOUR);
   endfunction
   // Builds one left-aligned sample word
   function automatic logic [WORD_W-1:0] make_word(
      input logic [CONV_BITS-1:0] code,
      input logic trig,
      input logic [DI_W-1:0] di
   );
      logic [WORD_W-1:0] w;
      w = '0;
      w[WORD_W-1 -: CONV_BITS] = code;
      w[TRIG_BIT] = trig;
      w[DI_W-1:0] = di;
      make_word = w;
   endfunction
   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   ssf_state_t state;
   ssf_state_t next_state;
   logic [2:0] chan_count;
   logic [XFER_W-1:0] xfer_len;
   logic [XFER_W-1:0] wr_total;
   logic [GAP_W-1:0] tick_gap;
   logic [WORD_W-1:0] stage [NUM_CH];
   logic [CONV_BITS-1:0] conv [NUM_CH];
   logic [1:0] ser_idx;
   logic [2:0] ser_left;
   logic [PTR_W:0] wr_ptr;
   logic [PTR_W:0] rd_ptr;
   logic [WORD_W-1:0] bank_rdata [NUM_BANKS];
   logic rd_inflight;
   logic rd_bank;
   logic [WORD_W-1:0] buf_head;
   logic [WORD_W-1:0] buf_tail;
   logic [1:0] buf_cnt;
   logic overflow;
   logic cfg_error;
   logic done;
   wire logic [DI_W-1:0] di_now;
   wire logic cfg_good;
   wire logic start_ok;
   wire logic start_bad;
   wire logic [PTR_W:0] fifo_level;
   wire logic fifo_full;
   wire logic fifo_empty;
   wire logic tick_ok;
   wire logic tick_take;
   wire logic ser_busy;
   wire logic need_more;
   wire logic wr_en;
   wire logic lost;
   wire logic [1:0] buf_occ;
   wire logic rd_issue;
   wire logic push;
   wire logic pop;
   wire logic drained;
   wire logic [WORD_W-1:0] rdata_sel;
   // -------------------------------------------------------------
   // Configuration and start decode
   // -------------------------------------------------------------
   // Only 0, 1, 2, 4 and lengths up to the limit are accepted
   assign cfg_good = ch_valid(i_enabled_channel_count) &&
                     (i_xfer_words <= MAX_LEN);
   assign start_ok = i_start && (state == SSF_IDLE) && cfg_good;
   assign start_bad = i_start && (state == SSF_IDLE) && !cfg_good;
   // -------------------------------------------------------------
   // Sample capture and serialising
   // -------------------------------------------------------------
   assign conv[0] = i_conv_ch0;
   assign conv[1] = i_conv_ch1;
   assign conv[2] = i_conv_ch2;
   assign conv[3] = i_conv_ch3;
   assign di_now = {i_digital_input_line_c, i_digital_input_line_b, i_digital_input_line_a};
   // Ticks closer than the least period are ignored
   assign tick_ok = (state == SSF_RUN) && i_sample_tick && (tick_gap == '0);
   assign ser_busy = (ser_left != 3'h0);
   assign tick_take = tick_ok && !ser_busy;
   assign need_more = (wr_total < xfer_len);
   assign fifo_level = wr_ptr - rd_ptr;
   assign fifo_full = (fifo_level == FULL_LVL);
   assign fifo_empty = (fifo_level == '0);
   assign wr_en = ser_busy && need_more && !fifo_full;
   // Full storage or a tick during serialising drops data
   assign lost = (ser_busy && need_more && fifo_full) || (tick_ok && ser_busy);
   // Tick spacing guard
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_gap <= '0;
      end else if (tick_ok) begin
         tick_gap <= GAP_LOAD;
      end else if (tick_gap != '0) begin
         tick_gap <= tick_gap - GAP_W'(1);
      end
   end
   // All channels latched on the same edge
   for (genvar g = 0; g < NUM_CH; g++) begin : g_stage
      always_ff @(posedge i_sys_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            stage[g] <= '0;
         end else if (tick_take) begin
            stage[g] <= make_word(conv[g], i_trigger_seen, di_now);
         end
      end
   end
   // Walks enabled channels in order 0, 1, 2, 3
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ser_idx <= 2'h0;
         ser_left <= 3'h0;
      end else if (tick_take) begin
         ser_idx <= 2'h0;
         ser_left <= chan_count;
      end else if (ser_busy) begin
         ser_idx <= ser_idx + 2'h1;
         ser_left <= ser_left - 3'h1;
      end
   end

   // -------------------------------------------------------------
   // Two-bank sample storage
   // -------------------------------------------------------------
   // Consecutive words alternate banks, one logical queue
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic [WORD_W-1:0] mem [BANK_WORDS];
      always_ff @(posedge i_sys_clk) begin
         if (wr_en && (wr_ptr[0] == 1'(b))) begin
            mem[wr_ptr[ADDR_W:1]] <= stage[ser_idx];
         end
         if (rd_issue && (rd_ptr[0] == 1'(b))) begin
            bank_rdata[b] <= mem[rd_ptr[ADDR_W:1]];
         end
      end
   end
   // Queue pointers and word count
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         wr_total <= '0;
      end else begin
         if (start_ok) begin
            wr_total <= '0;
         end else if (wr_en) begin
            wr_total <= wr_total + XFER_W'(1);
         end
         if (wr_en) begin
            wr_ptr <= wr_ptr + (PTR_W + 1)'(1);
         end
         if (rd_issue) begin
            rd_ptr <= rd_ptr + (PTR_W + 1)'(1);
         end
      end
   end

   // -------------------------------------------------------------
   // Two-entry output buffer
   // -------------------------------------------------------------
   // Reads start whenever a word waits and room exists
   assign buf_occ = buf_cnt + {1'b0, rd_inflight};
   assign rd_issue = !fifo_empty && (buf_occ < 2'(BUF_ENTRIES));
   assign push = rd_inflight;
   assign pop = o_dma_valid && i_dma_ready;
   assign rdata_sel = bank_rdata[rd_bank];
   assign o_dma_valid = (buf_cnt != 2'h0);
   assign o_dma_word = buf_head;
   // Read pipeline tracking
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_inflight <= 1'b0;
         rd_bank <= 1'b0;
      end else begin
         rd_inflight <= rd_issue;
         rd_bank <= rd_ptr[0];
      end
   end
   // Buffer shift on push and pop
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         buf_head <= '0;
         buf_tail <= '0;
         buf_cnt <= 2'h0;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               if (buf_cnt == 2'h0) begin
                  buf_head <= rdata_sel;
               end else begin
                  buf_tail <= rdata_sel;
               end
               buf_cnt <= buf_cnt + 2'h1;
            end
            2'b01: begin
               buf_head <= buf_tail;
               buf_cnt <= buf_cnt - 2'h1;
            end
            2'b11: begin
               if (buf_cnt == 2'h1) begin
                  buf_head <= rdata_sel;
               end else begin
                  buf_head <= buf_tail;
                  buf_tail <= rdata_sel;
               end
            end
            2'b00: begin
               buf_cnt <= buf_cnt;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Acquisition control
   // -------------------------------------------------------------
   assign drained = fifo_empty && !rd_inflight && (buf_cnt == 2'h0) && !ser_busy;
   // Next state selection
   always_comb begin
      next_state = state;
      unique case (state)
         SSF_IDLE: begin
            if (start_ok) begin
               next_state = SSF_RUN;
            end
         end
         SSF_RUN: begin
            if (i_stop || (!need_more && !ser_busy)) begin
               next_state = SSF_DRAIN;
            end
         end
         SSF_DRAIN: begin
            if (drained) begin
               next_state = SSF_IDLE;
            end
         end
         default: begin
            next_state = SSF_IDLE;
         end
      endcase
   end

   // State, settings and status flags
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= SSF_IDLE;
         chan_count <= CH_NONE;
         xfer_len <= '0;
         overflow <= 1'b0;
         cfg_error <= 1'b0;
         done <= 1'b0;
      end else begin
         state <= next_state;
         done <= (state == SSF_DRAIN) && drained;
         if (start_ok) begin
            chan_count <= i_enabled_channel_count;
            xfer_len <= (i_enabled_channel_count == CH_NONE) ? '0 : i_xfer_words;
         end
         // Set wins over the clear at start
         overflow <= lost || (overflow && !start_ok);
         cfg_error <= start_bad || (cfg_error && !start_ok);
      end
   end

   assign o_busy = (state != SSF_IDLE);
   assign o_done = done;
   assign o_overflow = overflow;
   assign o_cfg_error = cfg_error;
endmodule // ssf_sample_path

// ### inc/ssf_pkg.sv
// Purpose: Shared constants for the simultaneous sample path
// Assumes: 100 MHz system clock, 16-bit sample words
// Notes: Sample storage is split into two equal banks
package ssf_pkg;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SAMPLE_MAX_HZ = 20_000_000;
   // Least spacing of sample ticks, rounded up to whole cycles
   localparam int unsigned TICK_MIN_CYC = (CLK_HZ + SAMPLE_MAX_HZ - 1) / SAMPLE_MAX_HZ;

   // -------------------------------------------------------------
   // Storage and transfer sizes
   // -------------------------------------------------------------
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BANK_WORDS = 16384;
   localparam int unsigned NUM_BANKS = 2;
   localparam int unsigned FIFO_WORDS = BANK_WORDS * NUM_BANKS;
   localparam int unsigned BYTES_PER_WORD = 2;
   localparam longint unsigned MAX_XFER_BYTES = 64 * 1024 * 1024;
   localparam int unsigned MAX_XFER_WORDS = int'(MAX_XFER_BYTES / BYTES_PER_WORD);
   localparam int unsigned XFER_W = 26;
   localparam int unsigned BUF_ENTRIES = 2;

   // -------------------------------------------------------------
   // Sample word layout
   // -------------------------------------------------------------
   localparam int unsigned TRIG_BIT = 3;
   localparam int unsigned DI_W = 3;
   localparam int unsigned CONV_BITS_HI = 12;
   localparam int unsigned CONV_BITS_LO = 10;

   // -------------------------------------------------------------
   // Enabled channel count settings
   // -------------------------------------------------------------
   localparam logic [2:0] CH_NONE = 3'h0;
   localparam logic [2:0] CH_ONE = 3'h1;
   localparam logic [2:0] CH_TWO = 3'h2;
   localparam logic [2:0] CH_FOUR = 3'h4;

   typedef enum logic [1:0] {
      SSF_IDLE = 2'b00,
      SSF_RUN = 2'b01,
      SSF_DRAIN = 2'b10
   } ssf_state_t;
endpackage

// ### sim/ssf_dma_sink.sv
// Purpose: Bus master model that drains the word stream
// Assumes: Ready may stall on any cycle
// Notes: Popped words collect in one flat buffer
module ssf_dma_sink (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_stall,
   input wire logic i_valid,
   input wire logic [ssf_pkg::WORD_W-1:0] i_word,
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   import ssf_pkg::*;
   logic [WORD_W-1:0] got [$];
   // Ready follows the stall request one edge later
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ready <= 1'b0;
      end else begin
         o_ready <= !i_stall;
      end
   end
   // Store each accepted word in arrival order
   always @(posedge i_sys_clk) begin
      if (i_resetn && o_ready && i_valid) begin
         got.push_back(i_word);
      end
   end
endmodule // ssf_dma_sink

// ### sim/ssf_sample_path_sva.sv
// Purpose: Port assertions for the sample path
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached to every sample path instance by bind
module ssf_sample_path_sva (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic [2:0] i_enabled_channel_count,
   input wire logic [ssf_pkg::XFER_W-1:0] i_xfer_words,
   input wire logic i_dma_ready,
   input wire logic o_dma_valid,
   input wire logic [ssf_pkg::WORD_W-1:0] o_dma_word,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_overflow,
   input wire logic o_cfg_error
);
   timeunit 1ns;
   timeprecision 1ps;
   import ssf_pkg::*;
   // ---------------------------------------------------------------
   // Start decode and properties
   // ---------------------------------------------------------------
   wire logic take = i_start && !o_busy;
   wire logic cfg_ok = (i_enabled_channel_count inside {CH_NONE, CH_ONE, CH_TWO, CH_FOUR})
      && (i_xfer_words <= MAX_XFER_WORDS);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);
   start_accept_a: assert property (take && cfg_ok |=> o_busy && !o_cfg_error && !o_overflow)
      else $error("good start not taken");
   cfg_refuse_a: assert property (take && !cfg_ok |=> o_cfg_error && !o_busy)
      else $error("bad setting not refused");
   zero_run_a: assert property (take && cfg_ok && i_enabled_channel_count == CH_NONE
      |=> o_busy ##1 o_busy ##1 (o_done && !o_busy)) else $error("empty run timing");
   word_hold_a: assert property (o_dma_valid && !i_dma_ready
      |=> o_dma_valid && $stable(o_dma_word)) else $error("stalled word changed");
   done_pulse_a: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   busy_done_a: assert property ($fell(o_busy) |-> o_done)
      else $error("busy fell without done");
   idle_empty_a: assert property (!o_busy |-> !o_dma_valid)
      else $error("word offered while idle");
   overflow_sticky_a: assert property (o_overflow && !take |=> o_overflow)
      else $error("overflow flag lost");
   cover property ($rose(o_overflow));
   cover property (o_done);
   cover property ($rose(o_cfg_error));
endmodule // ssf_sample_path_sva

bind ssf_sample_path ssf_sample_path_sva ssf_sample_path_sva_inst (.i_sys_clk, .i_resetn,
   .i_start, .i_enabled_channel_count, .i_xfer_words, .i_dma_ready, .o_dma_valid,
   .o_dma_word, .o_busy, .o_done, .o_overflow, .o_cfg_error);

// ### sim/ssf_sample_path_tb.sv
// Purpose: Self-checking bench for the sample path
// Assumes: 100 MHz clock, 12-bit and 10-bit variants on one stimulus
// Notes: Queue model of capture order against popped words
module ssf_sample_path_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssf_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_start = 1'b0;
   logic i_stop = 1'b0;
   logic [2:0] i_enabled_channel_count = 3'h0;
   logic [XFER_W-1:0] i_xfer_words = '0;
   logic i_sample_tick = 1'b0;
   logic [11:0] cv [4] = '{default: 12'h000};
   logic [3:0] lo_in = 4'h0;
   logic stall = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [15:0] lfsr = 16'h001E;
   logic rdy, o_dma_valid, o_busy, o_done, o_overflow, o_cfg_error;
   logic [WORD_W-1:0] o_dma_word;
   logic rdy_b, valid_b, ovf_b;
   logic [WORD_W-1:0] word_b;
   int error_cnt = 0;
   int n_checks = 0;
   localparam logic [11:0] EDGE [4] = '{12'h7FF, 12'h800, 12'h000, 12'h001};
   localparam logic [2:0] BAD [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
   ssf_sample_path #(.CONV_BITS(12)) ssf_sample_path_inst (.i_sys_clk, .i_resetn, .i_start,
      .i_stop, .i_enabled_channel_count, .i_xfer_words, .i_sample_tick, .i_conv_ch0(cv[0]),
      .i_conv_ch1(cv[1]), .i_conv_ch2(cv[2]), .i_conv_ch3(cv[3]), .i_trigger_seen(lo_in[3]),
      .i_digital_input_line_c(lo_in[2]), .i_digital_input_line_b(lo_in[1]),
      .i_digital_input_line_a(lo_in[0]), .i_dma_ready(rdy), .o_dma_valid, .o_dma_word,
      .o_busy, .o_done, .o_overflow, .o_cfg_error);
   ssf_dma_sink ssf_dma_sink_inst (.i_sys_clk, .i_resetn, .i_stall(stall),
      .i_valid(o_dma_valid), .i_word(o_dma_word), .o_ready(rdy));
   // Narrow variant on the same stimulus, drained in lockstep
   ssf_sample_path #(.CONV_BITS(10)) ssf_sample_path_inst_b (.i_sys_clk, .i_resetn, .i_start,
      .i_stop, .i_enabled_channel_count, .i_xfer_words, .i_sample_tick,
      .i_conv_ch0(cv[0][11:2]), .i_conv_ch1(cv[1][11:2]), .i_conv_ch2(cv[2][11:2]),
      .i_conv_ch3(cv[3][11:2]), .i_trigger_seen(lo_in[3]), .i_digital_input_line_c(lo_in[2]),
      .i_digital_input_line_b(lo_in[1]), .i_digital_input_line_a(lo_in[0]),
      .i_dma_ready(rdy_b), .o_dma_valid(valid_b), .o_dma_word(word_b), .o_busy(),
      .o_done(), .o_overflow(ovf_b), .o_cfg_error());
   ssf_dma_sink ssf_dma_sink_inst_b (.i_sys_clk, .i_resetn, .i_stall(stall),
      .i_valid(valid_b), .i_word(word_b), .o_ready(rdy_b));
   // ---------------------------------------------------------------
   // Clock, random source and stall pattern
   // ---------------------------------------------------------------
   initial begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   // Next state of the random source
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   always @(posedge i_sys_clk) begin
      lfsr <= lfsr_next(lfsr);
      stall <= (mode == 2'h1) || (mode == 2'h0 && lfsr[0]);
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic start(input logic [2:0] n, input logic [XFER_W-1:0] len);
      @(posedge i_sys_clk);
      i_enabled_channel_count <= n;
      i_xfer_words <= len;
      i_start <= 1'b1;
      @(posedge i_sys_clk);
      i_start <= 1'b0;
      @(negedge i_sys_clk);
   endtask
   // One acquisition: ticks spaced 5 cycles, optional early tick, stop, full storage
   task automatic run(input int n, input int len, input int ticks, input bit fast,
      input bit stop, input bit full);
      logic [15:0] exp [$];
      logic [11:0] v [4];
      logic [3:0] lo;
      int k;
      int n_exp;
      ssf_dma_sink_inst.got.delete();
      ssf_dma_sink_inst_b.got.delete();
      mode <= full ? 2'h1 : 2'h0;
      start(3'(n), XFER_W'(len));
      check("busy", o_busy, 1'b1);
      for (int t = 0; t < ticks; t++) begin
         @(posedge i_sys_clk);
         lo = lfsr[15:12];
         for (int c = 0; c < 4; c++) begin
            v[c] = (t == 0) ? EDGE[c] : lfsr[11:0] ^ 12'(c * 857);
            cv[c] <= v[c];
            if (c < n && exp.size() < len) exp.push_back({v[c], lo});
         end
         lo_in <= lo;
         i_sample_tick <= 1'b1;
         @(posedge i_sys_clk);
         i_sample_tick <= 1'b0;
         @(posedge i_sys_clk);
         i_sample_tick <= fast && t == 0;
         @(posedge i_sys_clk);
         i_sample_tick <= 1'b0;
         @(posedge i_sys_clk);
      end
      if (stop) begin
         @(posedge i_sys_clk);
         i_stop <= 1'b1;
         @(posedge i_sys_clk);
         i_stop <= 1'b0;
      end
      mode <= full ? 2'h2 : 2'h0;
      for (k = 0; k < 70000; k++) begin
         @(negedge i_sys_clk);
         if (o_done === 1'b1) break;
      end
      if (k == 70000) begin
         error_cnt++;
         tally_and_finish();
      end
      check("idle", o_busy, 1'b0);
      check("overflow", o_overflow, full);
      check("overflow_b", ovf_b, full);
      // Full storage keeps both banks plus the output buffer, oldest words first
      n_exp = full ? int'(FIFO_WORDS + BUF_ENTRIES) : exp.size();
      if (full) begin
         check("kept", ssf_dma_sink_inst.got.size(), n_exp);
      end else begin
         check("count", ssf_dma_sink_inst.got.size(), n_exp);
      end
      check("count_b", ssf_dma_sink_inst_b.got.size(), n_exp);
      for (k = 0; k < n_exp && k < ssf_dma_sink_inst.got.size(); k++) begin
         check("word", ssf_dma_sink_inst.got[k], exp[k]);
      end
      for (k = 0; k < n_exp && k < ssf_dma_sink_inst_b.got.size(); k++) begin
         check("w10", ssf_dma_sink_inst_b.got[k], {exp[k][15:6], 2'h0, exp[k][3:0]});
      end
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check("reset", {o_dma_valid, o_busy, o_done, o_overflow, o_cfg_error}, 5'h00);
      check("reset_word", {o_dma_word, word_b}, 32'h00000000);
      @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      run(4, 10, 3, 1'b1, 1'b0, 1'b0);
      run(2, 6, 3, 1'b0, 1'b0, 1'b0);
      run(1, 100, 4, 1'b0, 1'b1, 1'b0);
      run(0, 8, 0, 1'b0, 1'b0, 1'b0);
      run(4, MAX_XFER_WORDS, 2, 1'b0, 1'b1, 1'b0);
      foreach (BAD[i]) begin
         start(BAD[i], 26'h0000004);
         check("cfg_error", o_cfg_error, 1'b1);
         check("refused", o_busy, 1'b0);
      end
      start(CH_FOUR, XFER_W'(MAX_XFER_WORDS + 1));
      check("cfg_len", o_cfg_error, 1'b1);
      run(4, 40000, 8200, 1'b0, 1'b1, 1'b1);
      tally_and_finish();
   end
endmodule // ssf_sample_path_tb
